// ---- design/bit_exec_pkg.sv ----
// constants for the bit set and test-skip execute block
package bit_exec_pkg;
  localparam int INSTR_W = 14;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int DATA_W = 8;
  // field positions inside an instruction word
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 10;
  localparam int BSEL_HI = 9;
  localparam int BSEL_LO = 7;
  localparam int ADDR_HI = 6;
  localparam int ADDR_LO = 0;
  // top four bits of each handled instruction
  localparam logic [3:0] OPC_SET_BIT = 4'h5;
  localparam logic [3:0] OPC_SKIP_CLEAR = 4'h6;
  localparam logic [3:0] OPC_SKIP_SET = 4'h7;
  // held word after reset: the no-operation encoding
  localparam logic [13:0] NO_OPERATION_WORD = 14'h0000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
endpackage

// ---- design/bit_field_decode.sv ----
// splits one instruction word into operation, bit mask and register address
`timescale 1ns/1ps
module bit_field_decode (
  // instruction in
  input wire logic [13:0] word,
  // decoded fields
  output logic is_set_bit,
  output logic is_skip_clear,
  output logic is_skip_set,
  output logic [2:0] bit_sel,
  output logic [6:0] reg_addr,
  output logic [7:0] bit_mask
);
  wire [3:0] opc = word[bit_exec_pkg::OPC_HI:bit_exec_pkg::OPC_LO];
  assign is_set_bit = (opc == bit_exec_pkg::OPC_SET_BIT);
  assign is_skip_clear = (opc == bit_exec_pkg::OPC_SKIP_CLEAR);
  assign is_skip_set = (opc == bit_exec_pkg::OPC_SKIP_SET);
  assign bit_sel = word[bit_exec_pkg::BSEL_HI:bit_exec_pkg::BSEL_LO];
  assign reg_addr = word[bit_exec_pkg::ADDR_HI:bit_exec_pkg::ADDR_LO];
  assign bit_mask = 8'h01 << bit_sel;
endmodule // bit_field_decode

// ---- design/bit_set_and_test_skip_exec.sv ----
// execute stage for bit set and bit test-skip instructions
`timescale 1ns/1ps
module bit_set_and_test_skip_exec (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // fetch stage
  input wire logic fetch_valid,
  input wire logic [13:0] fetch_word,
  // register file read port, combinational data for rd_addr
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  // register file write port
  output logic wr_en,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  // to core sequencing
  output logic [13:0] exec_word,
  output logic exec_valid,
  output logic skip_taken,
  output logic nop_slot,
  output logic flags_write
);
  // ------------------------------------------------------------
  // held instruction: prefetched word latched while previous runs
  // ------------------------------------------------------------
  logic [13:0] held_r;
  logic [13:0] held_nxt;
  logic held_valid_r;
  logic held_valid_nxt;

  // a gap keeps the old word but marks the slot empty
  assign held_nxt = fetch_valid ? fetch_word : held_r;
  assign held_valid_nxt = fetch_valid;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      held_r <= bit_exec_pkg::NO_OPERATION_WORD;
    end else begin
      held_r <= held_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      held_valid_r <= 1'b0;
    end else begin
      held_valid_r <= held_valid_nxt;
    end
  end

  // ------------------------------------------------------------
  // decode of the held word
  // ------------------------------------------------------------
  logic is_set_bit;
  logic is_skip_clear;
  logic is_skip_set;
  logic [2:0] bit_sel;
  logic [6:0] reg_addr;
  logic [7:0] bit_mask;

  bit_field_decode u_decode (
    .word(held_r),
    .is_set_bit(is_set_bit),
    .is_skip_clear(is_skip_clear),
    .is_skip_set(is_skip_set),
    .bit_sel(bit_sel),
    .reg_addr(reg_addr),
    .bit_mask(bit_mask)
  );

  // ------------------------------------------------------------
  // skip decision on the addressed register bit
  // ------------------------------------------------------------
  logic kill_r;
  logic kill_nxt;

  // a killed slot executes as no_operation, whatever it held
  wire live = held_valid_r & ~kill_r;
  wire killed_slot = held_valid_r & kill_r;
  wire bit_val = rd_data[bit_sel];
  wire set_hit = is_skip_set & bit_val;
  wire clear_hit = is_skip_clear & ~bit_val;
  wire skip_now = live & (set_hit | clear_hit);

  // ------------------------------------------------------------
  // skip kill: discard the word fetched during the test
  // ------------------------------------------------------------
  // armed by a taken skip, kept across fetch gaps, spent on the next slot
  assign kill_nxt = skip_now | (kill_r & ~held_valid_r);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      kill_r <= 1'b0;
    end else begin
      kill_r <= kill_nxt;
    end
  end

  // ------------------------------------------------------------
  // bit set: read, merge the mask, write back
  // ------------------------------------------------------------
  wire set_now = live & is_set_bit;
  wire [7:0] set_data = rd_data | bit_mask;
  // read port follows the held word's address field, same-cycle read
  assign rd_addr = held_r[bit_exec_pkg::ADDR_HI:bit_exec_pkg::ADDR_LO];

  // ------------------------------------------------------------
  // next values of the registered outputs
  // ------------------------------------------------------------
  logic wr_en_r;
  logic wr_en_nxt;
  logic [6:0] wr_addr_r;
  logic [6:0] wr_addr_nxt;
  logic [7:0] wr_data_r;
  logic [7:0] wr_data_nxt;
  logic [13:0] exec_word_r;
  logic [13:0] exec_word_nxt;
  logic exec_valid_r;
  logic exec_valid_nxt;
  logic skip_taken_r;
  logic skip_taken_nxt;
  logic nop_slot_r;
  logic nop_slot_nxt;
  logic flags_write_r;
  logic flags_write_nxt;

  assign wr_en_nxt = set_now;
  assign wr_addr_nxt = reg_addr;
  assign wr_data_nxt = set_data;
  // a discarded slot shows the no_operation word to the sequencer
  assign exec_word_nxt = live ? held_r : bit_exec_pkg::NO_OPERATION_WORD;
  assign exec_valid_nxt = held_valid_r;
  assign skip_taken_nxt = skip_now;
  // the discarded slot is the next valid slot after the skip, however many gap cycles come between
  assign nop_slot_nxt = killed_slot;
  // none of these instructions touches the status flags
  assign flags_write_nxt = 1'b0;

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_en_r <= 1'b0;
    end else begin
      wr_en_r <= wr_en_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_addr_r <= bit_exec_pkg::ADDR_RESET;
    end else begin
      wr_addr_r <= wr_addr_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_data_r <= bit_exec_pkg::DATA_RESET;
    end else begin
      wr_data_r <= wr_data_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      exec_word_r <= bit_exec_pkg::NO_OPERATION_WORD;
    end else begin
      exec_word_r <= exec_word_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      exec_valid_r <= 1'b0;
    end else begin
      exec_valid_r <= exec_valid_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      skip_taken_r <= 1'b0;
    end else begin
      skip_taken_r <= skip_taken_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nop_slot_r <= 1'b0;
    end else begin
      nop_slot_r <= nop_slot_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_write_r <= 1'b0;
    end else begin
      flags_write_r <= flags_write_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, each straight from its register
  // ------------------------------------------------------------
  assign wr_en = wr_en_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign exec_word = exec_word_r;
  assign exec_valid = exec_valid_r;
  assign skip_taken = skip_taken_r;
  assign nop_slot = nop_slot_r;
  assign flags_write = flags_write_r;

endmodule // bit_set_and_test_skip_exec

// ---- verification/bit_exec_checker.sv ----
// assertions for the bit set and test-skip execute block
`timescale 1ns/1ps
module bit_exec_checker (
  // block ports
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic fetch_valid,
  input wire logic [13:0] fetch_word,
  input wire logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [13:0] exec_word,
  input wire logic exec_valid,
  input wire logic skip_taken,
  input wire logic nop_slot,
  input wire logic flags_write
);
  logic [13:0] w_r;
  wire hit = rd_data[w_r[9:7]] == w_r[10];
  always_ff @(posedge clock) if (fetch_valid) w_r <= fetch_word;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_read_addr: assert property (fetch_valid |=> rd_addr == $past(fetch_word[6:0])) else $error("bad rd_addr");
  a_set_write: assert property (fetch_valid ##1 fetch_valid && fetch_word[13:10] == 4'h5 ##1 !skip_taken |=>
    wr_en && wr_addr == $past(w_r[6:0]) && wr_data == $past(rd_data | (8'h01 << w_r[9:7]))) else $error("bad write");
  a_skip_decide: assert property (fetch_valid ##1 fetch_valid && fetch_word[13:11] == 3'h3
    ##1 !skip_taken |=> skip_taken == $past(hit)) else $error("bad skip");
  a_kill_slot: assert property (skip_taken && $past(fetch_valid) |=> nop_slot && !wr_en && !skip_taken &&
    exec_word == 14'h0000) else $error("slot not killed");
  a_exec_slot: assert property (fetch_valid ##1 fetch_valid ##1 !skip_taken |=> exec_valid &&
    exec_word == $past(w_r)) else $error("bad exec word");
  a_no_flags: assert property (!flags_write) else $error("flags written");
  cover property (skip_taken);
  cover property (wr_en);
  cover property (nop_slot);
endmodule // bit_exec_checker
bind bit_set_and_test_skip_exec bit_exec_checker chk_i (.*);

// ---- verification/tb_bit_set_and_test_skip_exec.sv ----
// self-checking bench for the bit set and test-skip execute block
`timescale 1ns/1ps
module tb_bit_set_and_test_skip_exec;
  logic clock, sys_rst, fetch_valid, wr_en, exec_valid, skip_taken, nop_slot, flags_write;
  logic [13:0] fetch_word, exec_word;
  logic [6:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data;
  int fails, tests_run;
  bit_set_and_test_skip_exec dut (.*);
  task complete_run;
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(logic [13:0] s, logic [13:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task go(logic [13:0] w);
    @(posedge clock);
    fetch_valid <= 1'b1;
    fetch_word <= w;
  endtask
  // word a then b back to back, register data d; returns with a's results out
  task pair(logic [7:0] d, logic [13:0] a, logic [13:0] b);
    go(a);
    rd_data <= d;
    go(b);
    go(14'h0000);
    #1;
  endtask
  task t_set_bit;
    pair(8'h0A, 14'h17FF, 14'h0000);
    chk(wr_en, 1'b1);
    chk(wr_addr, 7'h7F);
    chk(wr_data, 8'h8A);
  endtask
  task t_skip_set;
    pair(8'h02, 14'h1C85, 14'h1485);
    chk(skip_taken, 1'b1);
    chk(exec_word, 14'h1C85);
    @(posedge clock);
    #1;
    chk(nop_slot, 1'b1);
    chk(wr_en, 1'b0);
    chk(exec_word, 14'h0000);
    chk(exec_valid, 1'b1);
    chk(flags_write, 1'b0);
  endtask
  task t_skip_clear;
    pair(8'hFE, 14'h1800, 14'h1485);
    chk(skip_taken, 1'b1);
    pair(8'hFD, 14'h1C85, 14'h0000);
    chk(skip_taken, 1'b0);
  endtask
  task t_no_skip;
    pair(8'h80, 14'h1B85, 14'h1485);
    chk(skip_taken, 1'b0);
    @(posedge clock);
    #1;
    chk(wr_data, 8'h82);
    chk(nop_slot, 1'b0);
  endtask
  task idle;
    @(posedge clock);
    fetch_valid <= 1'b0;
  endtask
  // taken skip, then a fetch gap: the first word after the gap is discarded
  task t_gap_kill;
    go(14'h1C85);
    rd_data <= 8'h02;
    idle;
    idle;
    #1;
    chk(skip_taken, 1'b1);
    idle;
    #1;
    chk(skip_taken, 1'b0);
    chk(exec_valid, 1'b0);
    go(14'h1485);
    go(14'h1505);
    go(14'h0000);
    #1;
    chk(nop_slot, 1'b1);
    chk(wr_en, 1'b0);
    chk(exec_valid, 1'b1);
    chk(rd_addr, 7'h05);
    @(posedge clock);
    #1;
    chk(wr_en, 1'b1);
    chk(wr_data, 8'h06);
    chk(exec_word, 14'h1505);
  endtask
  // reset lands on the skip's decision edge: nothing decided, nothing discarded
  task t_reset_mid;
    go(14'h1C85);
    go(14'h1505);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    chk(skip_taken, 1'b0);
    chk(exec_valid, 1'b0);
    chk(exec_word, 14'h0000);
    chk(wr_en, 1'b0);
    chk(flags_write, 1'b0);
    go(14'h0000);
    @(posedge clock);
    #1;
    chk(wr_en, 1'b1);
    chk(wr_data, 8'h06);
    chk(exec_word, 14'h1505);
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    {sys_rst, fetch_valid, fetch_word, rd_data, fails, tests_run} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_set_bit;
    t_skip_set;
    t_skip_clear;
    t_no_skip;
    t_gap_kill;
    t_reset_mid;
    complete_run;
  end
  initial begin
    #2000;
    fails++;
    complete_run;
  end
endmodule // tb_bit_set_and_test_skip_exec
